/* pkg/scp_pkg.sv */
// Purpose : Shared constants and types of the sense clip mode control block
// Assumes : Avalon-MM byte addresses, one 32-bit word per register
// Notes   : All offsets, most field positions and the pass and watch reset values live here
package scp_pkg;
  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [5:0] OFS_MODE = 6'h00;  // Probe mode and group select
  localparam logic [5:0] OFS_WHI  = 6'h04;  // watch_address_hi
  localparam logic [5:0] OFS_WLO  = 6'h08;  // watch_address_lo
  localparam logic [5:0] OFS_USE  = 6'h0C;  // Other-use claims of watch regs
  localparam logic [5:0] OFS_EVT  = 6'h10;  // event_mode_register
  localparam logic [5:0] OFS_PASS = 6'h14;  // pass_count_command
  localparam logic [5:0] OFS_STAT = 6'h18;  // Sticky status, clear on read
  localparam logic [5:0] OFS_MASK = 6'h1C;  // Interrupt mask
  localparam logic [5:0] OFS_PIN  = 6'h20;  // Live probe input levels
  localparam logic [5:0] OFS_LEFT = 6'h24;  // Passes still to go

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_IN   = 2'b00,  // All pins inputs
    MODE_EVT  = 2'b01,  // Bit 0 event output
    MODE_DATA = 2'b11   // Nibble data output
  } scp_mode_t;
  localparam int MODE_HI_BIT  = 2;   // Select watch_address_hi group
  localparam int MODE_LO_BIT  = 3;   // Select watch_address_lo group
  localparam int EVT_CARE_LSB = 8;   // Care mask field
  localparam int EVT_EN_BIT   = 16;  // Probe condition enable
  localparam int NSTAT        = 4;
  localparam int ST_FIRE      = 0;   // Pass count reached
  localparam int ST_MODE_REJ  = 1;   // Malformed mode request
  localparam int ST_PASS_REJ  = 2;   // Pass count out of range
  localparam int ST_USE_REJ   = 3;   // Watch register conflict
  localparam logic [7:0]  PASS_RST  = 8'h01;
  localparam logic [7:0]  PASS_MIN  = 8'h01;
  localparam logic [15:0] WATCH_RST = 16'h0000;
endpackage : scp_pkg

/* pkg/scp_cnt_if.sv */
// Purpose : Carrier between mode control and its pass counter
// Assumes : Single clock domain
// Notes   : Count is held steady by the controller
`timescale 1ns/1ps
interface scp_cnt_if;
  logic       load;   // Reload from count
  logic [7:0] count;  // Programmed pass count
  logic       hit;    // One detection occurrence
  logic       fire;   // Pass count reached, one pulse
  logic [7:0] left;   // Occurrences still to go
  modport ctl (output load, count, hit, input fire, left);
  modport cnt (input load, count, hit, output fire, left);
endinterface : scp_cnt_if

/* core/scp_pass_counter.sv */
// Purpose : Pass counter of combined event detection
// Assumes : Count never zero, enforced by the controller
// Notes   : Fire is a one-cycle pulse on the last pass
`timescale 1ns/1ps
module scp_pass_counter
  import scp_pkg::*;
(
  input wire logic clk,     // System clock
  input wire logic resetn,  // Synchronous reset, active low
  scp_cnt_if.cnt   c        // Counter side
);
  logic [7:0] left_r, left_nxt;
  logic       fire_r, fire_nxt;

  // Count down per hit, reload after firing
  always_comb begin
    left_nxt = left_r;
    fire_nxt = 1'b0;
    if (c.load) begin
      left_nxt = c.count;
    end else if (c.hit) begin
      if (left_r <= PASS_MIN) begin
        fire_nxt = 1'b1;
        left_nxt = c.count;
      end else begin
        left_nxt = left_r - PASS_MIN;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      left_r <= PASS_RST;
      fire_r <= 1'b0;
    end else begin
      left_r <= left_nxt;
      fire_r <= fire_nxt;
    end
  end

  assign c.left = left_r;
  assign c.fire = fire_r;
endmodule : scp_pass_counter

/* core/scp_watch_nib.sv */
// Purpose : Address watch for one output nibble
// Assumes : One data memory access per valid cycle
// Notes   : Holds the last matched value between matches
`timescale 1ns/1ps
module scp_watch_nib
  import scp_pkg::*;
(
  input  wire logic        clk,       // System clock
  input  wire logic        resetn,    // Synchronous reset, active low
  input  wire logic [15:0] watchAddr, // Watched address
  input  wire logic [15:0] memAddr,   // Access address
  input  wire logic        memValid,  // Access strobe
  input  wire logic [3:0]  nibIn,     // Data nibble of access
  output logic      [3:0]  nibOut     // Latched nibble
);
  logic [3:0] nib_r, nib_nxt;

  // Capture only on address match
  always_comb begin
    nib_nxt = nib_r;
    if (memValid && memAddr == watchAddr) begin
      nib_nxt = nibIn;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      nib_r <= 4'h0;
    end else begin
      nib_r <= nib_nxt;
    end
  end

  assign nibOut = nib_r;
endmodule : scp_watch_nib

/* core/scp_mode_ctrl.sv */
// Purpose : Sense clip mode control with event pass counting
// Assumes : Avalon-MM slave, probe inputs synchronous to clk
// Notes   : Every output is a flip-flop
//
// Summary of operation
// - In input mode all eight probe pins are inputs and none is driven.
// - In event mode pins 1 to 7 are inputs and pin 0 is the event output.
// - In data mode the pins form a low and a high nibble, each an output on its own.
// - The hi watch address feeds pins 4 to 7, the lo one pins 0 to 3, both give all eight.
// - An output nibble shows memory data when the access address matches its watch register.
// - Input pins are sampled and changes are written to the trace memory.
// - Input levels against the event pattern form an event detection condition.
// - Pin 0 event output only ever pulls low and the far side supplies the pull-up.
// - A watch register used elsewhere cannot drive output, and one driving output cannot be claimed.
// - The current mode and group selection read back from the mode register.
// - A mode change only alters pin directions and sources, with no check of wiring.
// - The event is signalled only after detection has occurred pass-count times.
// - Pass count accepts only 1 to 255 and other values are refused.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module scp_mode_ctrl
  import scp_pkg::*;
(
  input  wire logic        clk,            // 250 MHz system clock
  input  wire logic        resetn,         // Synchronous reset, active low
  input  wire logic [5:0]  address,        // Avalon byte address
  input  wire logic        read,           // Avalon read
  input  wire logic        write,          // Avalon write
  input  wire logic [31:0] writedata,      // Avalon write data
  input  wire logic [3:0]  byteenable,     // Avalon byte lanes
  output logic      [31:0] readdata,       // Avalon read data
  output logic             waitrequest,    // Avalon stall
  output logic             irq,            // Level interrupt
  input  wire logic [7:0]  probeIn,        // Probe pin levels
  output logic      [7:0]  probeOut,       // Probe drive value
  output logic      [7:0]  probeOe,        // Probe drive enable
  input  wire logic [15:0] memAddr,        // Data memory access address
  input  wire logic [7:0]  memData,        // Data read or written
  input  wire logic        memValid,       // Access strobe
  output logic      [7:0]  traceData,      // Sampled input pins
  output logic             traceWe,        // Trace memory write
  output logic             eventDet        // Pass count reached, pulse
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Byte-lane merge of a write into a register view
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction : laneMerge

  // Pins that are inputs for a given mode and group selection
  function automatic logic [7:0] inMask(input scp_mode_t m, input logic hi,
                                        input logic lo);
    logic [7:0] res;
    res = 8'hFF;
    case (m)
      MODE_EVT:  res = 8'hFE;
      MODE_DATA: res = ~{{4{hi}}, {4{lo}}};
      default:   res = 8'hFF;
    endcase
    return res;
  endfunction : inMask

  // ****************************************************************
  // State
  // ****************************************************************
  scp_mode_t   mode_r, mode_nxt;
  logic        selHi_r, selHi_nxt, selLo_r, selLo_nxt;
  logic [15:0] wHi_r, wHi_nxt, wLo_r, wLo_nxt;
  logic [1:0]  use_r, use_nxt;
  logic [16:0] evt_r, evt_nxt;
  logic [7:0]  pass_r, pass_nxt;
  logic [NSTAT-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic        wait_r, wait_nxt, irq_r, irq_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        cond_r, cond_nxt, load_r, load_nxt;
  logic [7:0]  pOut_r, pOut_nxt, pOe_r, pOe_nxt;
  logic [7:0]  trD_r, trD_nxt;
  logic        trWe_r, trWe_nxt, det_r;
  logic [3:0]  nibHi, nibLo;
  logic        rdAcc, wrAcc, cond;
  logic [31:0] wv;
  logic [NSTAT-1:0] setSt;

  scp_cnt_if cnt ();

  // ****************************************************************
  // Submodules
  // ****************************************************************
  // Pass counter of combined detection
  scp_pass_counter u_pass (.clk(clk), .resetn(resetn), .c(cnt));

  // Nibble watches, data bit positions follow the pins
  scp_watch_nib u_hi (.clk(clk), .resetn(resetn), .watchAddr(wHi_r),
    .memAddr(memAddr), .memValid(memValid), .nibIn(memData[7:4]), .nibOut(nibHi));
  scp_watch_nib u_lo (.clk(clk), .resetn(resetn), .watchAddr(wLo_r),
    .memAddr(memAddr), .memValid(memValid), .nibIn(memData[3:0]), .nibOut(nibLo));

  assign cnt.load  = load_r;
  assign cnt.count = pass_r;
  assign cnt.hit   = cond && !cond_r;  // Count each rising occurrence

  // Access is taken on the edge where waitrequest is seen low
  assign rdAcc = read && !wait_r;
  assign wrAcc = write && !wait_r;

  // Probe condition on input pins only
  assign cond = evt_r[EVT_EN_BIT] &&
                (((probeIn ^ evt_r[7:0]) & evt_r[EVT_CARE_LSB +: 8]
                  & inMask(mode_r, selHi_r, selLo_r)) == 8'h00);

  // ****************************************************************
  // Register file and bus
  // ****************************************************************
  // Next values of all software state
  always_comb begin
    mode_nxt  = mode_r;
    selHi_nxt = selHi_r;
    selLo_nxt = selLo_r;
    wHi_nxt   = wHi_r;
    wLo_nxt   = wLo_r;
    use_nxt   = use_r;
    evt_nxt   = evt_r;
    pass_nxt  = pass_r;
    mask_nxt  = mask_r;
    load_nxt  = 1'b0;
    setSt     = '0;
    wv        = 32'h0000_0000;
    wait_nxt  = 1'b1;
    rd_nxt    = rd_r;
    setSt[ST_FIRE] = cnt.fire;
    // One wait cycle per access, then back to stall
    if ((read || write) && wait_r) begin
      wait_nxt = 1'b0;
    end
    if (read && wait_r) begin
      case (address)
        OFS_MODE: rd_nxt = {28'h0, selLo_r, selHi_r, mode_r};
        OFS_WHI:  rd_nxt = {16'h0, wHi_r};
        OFS_WLO:  rd_nxt = {16'h0, wLo_r};
        OFS_USE:  rd_nxt = {30'h0, use_r};
        OFS_EVT:  rd_nxt = {15'h0, evt_r};
        OFS_PASS: rd_nxt = {24'h0, pass_r};
        OFS_STAT: rd_nxt = {28'h0, stat_r};
        OFS_MASK: rd_nxt = {28'h0, mask_r};
        OFS_PIN:  rd_nxt = {24'h0, probeIn};
        OFS_LEFT: rd_nxt = {24'h0, cnt.left};
        default:  rd_nxt = 32'h0000_0000;
      endcase
    end
    if (wrAcc) begin
      case (address)
        OFS_MODE: begin
          wv = laneMerge({28'h0, selLo_r, selHi_r, mode_r}, writedata, byteenable);
          if (wv[1:0] == MODE_DATA) begin
            if (!wv[MODE_HI_BIT] && !wv[MODE_LO_BIT]) begin
              setSt[ST_MODE_REJ] = 1'b1;
            end else if ((wv[MODE_HI_BIT] && use_r[0]) ||
                         (wv[MODE_LO_BIT] && use_r[1])) begin
              setSt[ST_USE_REJ] = 1'b1;
            end else begin
              mode_nxt  = MODE_DATA;
              selHi_nxt = wv[MODE_HI_BIT];
              selLo_nxt = wv[MODE_LO_BIT];
            end
          end else if (wv[1:0] == MODE_IN || wv[1:0] == MODE_EVT) begin
            mode_nxt  = scp_mode_t'(wv[1:0]);
            selHi_nxt = 1'b0;
            selLo_nxt = 1'b0;
          end else begin
            setSt[ST_MODE_REJ] = 1'b1;
          end
        end
        OFS_WHI: begin
          wv = laneMerge({16'h0, wHi_r}, writedata, byteenable);
          wHi_nxt = wv[15:0];
        end
        OFS_WLO: begin
          wv = laneMerge({16'h0, wLo_r}, writedata, byteenable);
          wLo_nxt = wv[15:0];
        end
        OFS_USE: begin
          wv = laneMerge({30'h0, use_r}, writedata, byteenable);
          if ((wv[0] && mode_r == MODE_DATA && selHi_r) ||
              (wv[1] && mode_r == MODE_DATA && selLo_r)) begin
            setSt[ST_USE_REJ] = 1'b1;
          end else begin
            use_nxt = wv[1:0];
          end
        end
        OFS_EVT: begin
          wv = laneMerge({15'h0, evt_r}, writedata, byteenable);
          evt_nxt = wv[16:0];
        end
        OFS_PASS: begin
          wv = laneMerge({24'h0, pass_r}, writedata, byteenable);
          if (wv[31:8] != 24'h0 || wv[7:0] < PASS_MIN) begin
            setSt[ST_PASS_REJ] = 1'b1;
          end else begin
            pass_nxt = wv[7:0];
            load_nxt = 1'b1;
          end
        end
        OFS_MASK: begin
          wv = laneMerge({28'h0, mask_r}, writedata, byteenable);
          mask_nxt = wv[NSTAT-1:0];
        end
        default: wv = 32'h0000_0000;
      endcase
    end
    // Read clears only what it reported, so a new set is kept
    stat_nxt = stat_r;
    if (rdAcc && address == OFS_STAT) begin
      stat_nxt = stat_r & ~rd_r[NSTAT-1:0];
    end
    stat_nxt = stat_nxt | setSt;
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  // Software state, reset to all inputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_r  <= MODE_IN;
      selHi_r <= 1'b0;
      selLo_r <= 1'b0;
      wHi_r   <= WATCH_RST;
      wLo_r   <= WATCH_RST;
      use_r   <= 2'b00;
      evt_r   <= '0;
      pass_r  <= PASS_RST;
      stat_r  <= '0;
      mask_r  <= '0;
      wait_r  <= 1'b1;
      rd_r    <= 32'h0000_0000;
      irq_r   <= 1'b0;
      load_r  <= 1'b1;
    end else begin
      mode_r  <= mode_nxt;
      selHi_r <= selHi_nxt;
      selLo_r <= selLo_nxt;
      wHi_r   <= wHi_nxt;
      wLo_r   <= wLo_nxt;
      use_r   <= use_nxt;
      evt_r   <= evt_nxt;
      pass_r  <= pass_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      wait_r  <= wait_nxt;
      rd_r    <= rd_nxt;
      irq_r   <= irq_nxt;
      load_r  <= load_nxt;
    end
  end

  // ****************************************************************
  // Probe pins and trace
  // ****************************************************************
  // Directions follow the mode, group selection and fire status; wiring is never probed
  always_comb begin
    pOut_nxt = 8'h00;
    pOe_nxt  = 8'h00;
    case (mode_r)
      MODE_EVT: begin
        pOe_nxt[0] = stat_r[ST_FIRE];  // Pull low only
      end
      MODE_DATA: begin
        pOe_nxt  = {{4{selHi_r}}, {4{selLo_r}}};
        pOut_nxt = {nibHi, nibLo} & pOe_nxt;
      end
      default: pOe_nxt = 8'h00;
    endcase
    // Driven pins read as zero in the trace
    trD_nxt  = probeIn & inMask(mode_r, selHi_r, selLo_r);
    trWe_nxt = (trD_nxt != trD_r);
    cond_nxt = cond;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pOut_r <= 8'h00;
      pOe_r  <= 8'h00;
      trD_r  <= 8'h00;
      trWe_r <= 1'b0;
      cond_r <= 1'b0;
      det_r  <= 1'b0;
    end else begin
      pOut_r <= pOut_nxt;
      pOe_r  <= pOe_nxt;
      trD_r  <= trD_nxt;
      trWe_r <= trWe_nxt;
      cond_r <= cond_nxt;
      det_r  <= cnt.fire;
    end
  end

  assign readdata    = rd_r;
  assign waitrequest = wait_r;
  assign irq         = irq_r;
  assign probeOut    = pOut_r;
  assign probeOe     = pOe_r;
  assign traceData   = trD_r;
  assign traceWe     = trWe_r;
  assign eventDet    = det_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_input_no_drive: assert property ($past(mode_r) == MODE_IN |-> probeOe == 8'h00)
    else $error("pin driven in input mode");
  a_evt_bit_zero: assert property ($past(mode_r) == MODE_EVT |-> probeOe[7:1] == 7'h00)
    else $error("upper pins driven in event mode");
  a_data_groups: assert property ($past(mode_r) == MODE_DATA |->
    probeOe == {{4{$past(selHi_r)}}, {4{$past(selLo_r)}}})
    else $error("nibble enables wrong");
  a_open_collector: assert property (probeOut[0] == 1'b0 || probeOe[0] == 1'b0 ||
    $past(mode_r) == MODE_DATA)
    else $error("event pin driven high");
  a_use_exclusive: assert property (mode_r == MODE_DATA |->
    !((selHi_r && use_r[0]) || (selLo_r && use_r[1])))
    else $error("watch register used twice");
  a_mode_neither: assert property (wrAcc && address == OFS_MODE && byteenable[0] &&
    writedata[1:0] == MODE_DATA && writedata[3:2] == 2'b00 |=> $stable(mode_r) && stat_r[ST_MODE_REJ])
    else $error("empty data mode accepted");
  a_pass_range: assert property (wrAcc && address == OFS_PASS && byteenable == 4'hF &&
    writedata == 32'h0 |=> $stable(pass_r) && stat_r[ST_PASS_REJ])
    else $error("zero pass count accepted");
  a_fire_status: assert property (cnt.fire |=> stat_r[ST_FIRE] && eventDet)
    else $error("fire not recorded");
  a_fire_last: assert property (cnt.fire |-> $past(cnt.left) == PASS_MIN)
    else $error("fire before last pass");
  a_mode_next_edge: assert property (wrAcc && address == OFS_MODE && byteenable[0] &&
    writedata[1:0] == MODE_IN |=> mode_r == MODE_IN ##1 probeOe == 8'h00)
    else $error("mode change late");
  a_bus_one_wait: assert property ((read || write) && wait_r |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest timing");
  a_irq_level: assert property (irq == |(stat_r & mask_r))
    else $error("irq level mismatch");

  c_event_fire: cover property (mode_r == MODE_EVT ##[1:50] probeOe[0]);
  c_both_nibbles: cover property (mode_r == MODE_DATA && selHi_r && selLo_r);
  c_use_reject: cover property (setSt[ST_USE_REJ]);
  c_trace_write: cover property (traceWe);
endmodule : scp_mode_ctrl

/* testbench/scp_probe_model.sv */
// Purpose : Far side of the probe clip, resolves each pin
// Assumes : Target drives only where extOe is high
// Notes   : Bit 0 has a pull-up, other idle pins take the inverse of probeOut
`timescale 1ns/1ps
module scp_probe_model (
  input  wire logic [7:0] probeOut, // Block drive value
  input  wire logic [7:0] probeOe,  // Block drive enable
  input  wire logic [7:0] extDrv,   // Target drive value
  input  wire logic [7:0] extOe,    // Target drive enable
  output logic      [7:0] pin       // Resolved pin level
);
  // ****************************************************************
  // Pin resolution
  // ****************************************************************
  // Block wins so a driven pin never shows target level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (probeOe[i]) pin[i] = probeOut[i];
      else if (extOe[i]) pin[i] = extDrv[i];
      else pin[i] = (i == 0) ? 1'b1 : ~probeOut[i]; // Pull-up on bit 0
    end
  end
endmodule : scp_probe_model

/* testbench/sense_clip_mode_control_bench.sv */
// Purpose : Self-checking bench of the sense clip mode control
// Assumes : Slave answers within fifty cycles of a request
// Notes   : Probe settle waits follow the two-register path
`timescale 1ns/1ps
module sense_clip_mode_control_bench;
  import scp_pkg::*;
  logic clk = 0, resetn = 0, read = 0, write = 0, memValid = 0;
  logic [5:0]  address = 6'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [15:0] memAddr = 16'h0;
  logic [7:0]  memData = 8'h00, probeIn, probeOut, probeOe, traceData;
  logic [7:0]  extDrv = 8'h00, extOe = 8'hFE;
  logic        waitrequest, irq, traceWe, eventDet;
  int          failures = 0, tests_run = 0, cyc = 0, evCnt = 0, twCnt = 0;
  always #2 clk = ~clk;
  scp_mode_ctrl dut (.clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .probeIn(probeIn), .probeOut(probeOut),
    .probeOe(probeOe), .memAddr(memAddr), .memData(memData), .memValid(memValid),
    .traceData(traceData), .traceWe(traceWe), .eventDet(eventDet));
  scp_probe_model model (.probeOut(probeOut), .probeOe(probeOe), .extDrv(extDrv),
    .extOe(extOe), .pin(probeIn));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Cycle ceiling and event pulse count
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (eventDet === 1'b1) evCnt <= evCnt + 1;
    if (traceWe === 1'b1) twCnt <= twCnt + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One Avalon access; request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a; write <= wr; read <= !wr; writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0; write <= 1'b0;
    if (n >= 50) begin
      chk("bus answer", 32'h0, 32'h1);
      end_sim();
    end
  endtask : bus
  task automatic mem(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    memAddr <= a; memData <= d; memValid <= 1'b1;
    @(posedge clk);
    memValid <= 1'b0;
  endtask : mem
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk("oe after reset", probeOe, 8'h00);
    bus(0, OFS_MODE, 0); chk("mode reset", q, 32'h0);
    bus(0, OFS_PASS, 0); chk("pass reset", q, PASS_RST);
    bus(0, 6'h3C, 0); chk("unmapped", q, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_pass;
    bus(1, OFS_PASS, 32'h0); bus(1, OFS_PASS, 32'h100);
    bus(0, OFS_STAT, 0); chk("pass reject", q, 32'h4);
    bus(0, OFS_PASS, 0); chk("pass kept", q, 32'h1);
    bus(1, OFS_PASS, 32'hFF); bus(0, OFS_PASS, 0); chk("pass max", q, 32'hFF);
    bus(1, OFS_PASS, 32'h3);
    $display("test pass done");
  endtask : t_pass
  task automatic t_event;
    bus(1, OFS_MODE, 32'h1); bus(0, OFS_MODE, 0); chk("mode evt", q, 32'h1);
    chk("oe evt idle", probeOe, 8'h00);
    bus(1, OFS_MASK, 32'h1); bus(1, OFS_EVT, 32'h1F0A0);
    for (int i = 1; i <= 3; i++) begin
      @(posedge clk) extDrv <= 8'hA0;
      repeat (6) @(posedge clk);
      extDrv <= 8'h00;
      repeat (6) @(posedge clk);
      chk("event count", evCnt, (i == 3) ? 1 : 0);
    end
    chk("event oe", probeOe, 8'h01);
    chk("event low", probeIn[0], 1'b0);
    chk("irq set", irq, 1'b1);
    bus(0, OFS_STAT, 0); chk("fire status", q, 32'h1);
    repeat (4) @(posedge clk);
    chk("event release", probeIn[0], 1'b1);
    chk("irq clear", irq, 1'b0);
    $display("test event done");
  endtask : t_event
  task automatic t_data;
    extOe <= 8'h00;
    bus(1, OFS_MODE, 32'h3); bus(0, OFS_STAT, 0); chk("no group", q, 32'h2);
    bus(1, OFS_WHI, 32'h1234); bus(1, OFS_WLO, 32'h5678); // Watch set first
    bus(1, OFS_MODE, 32'hF); bus(0, OFS_MODE, 0); chk("mode data", q, 32'hF);
    chk("all out", probeOe, 8'hFF);
    mem(16'h1234, 8'hAB); mem(16'h5678, 8'hCD); mem(16'h9999, 8'h11);
    repeat (4) @(posedge clk);
    chk("nibbles", probeOut, 8'hAD);
    bus(1, OFS_USE, 32'h1); bus(0, OFS_STAT, 0); chk("claim busy", q, 32'h8);
    bus(1, OFS_MODE, 32'h1); bus(1, OFS_USE, 32'h1); bus(1, OFS_MODE, 32'h7);
    bus(0, OFS_STAT, 0); chk("group busy", q, 32'h8);
    bus(1, OFS_USE, 32'h0); bus(1, OFS_MODE, 32'h7);
    repeat (3) @(posedge clk);
    chk("hi only", probeOe, 8'hF0);
    $display("test data done");
  endtask : t_data
  task automatic t_input;
    int tw;
    bus(1, OFS_MODE, 32'h0);
    @(posedge clk) begin extDrv <= 8'h5A; extOe <= 8'hFF; end
    repeat (4) @(posedge clk);
    chk("all in", probeOe, 8'h00);
    chk("trace", traceData, 8'h5A);
    bus(0, OFS_PIN, 0); chk("pin level", q, 32'h5A);
    // One pin change gives exactly one trace write
    tw = twCnt;
    @(posedge clk) extDrv <= 8'h5B;
    repeat (4) @(posedge clk);
    chk("trace pulse", twCnt - tw, 1);
    chk("trace new", traceData, 8'h5B);
    $display("test input done");
  endtask : t_input
  task automatic end_sim;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_reset(); t_pass(); t_event(); t_data(); t_input();
    end_sim();
  end
endmodule : sense_clip_mode_control_bench
